/* File: shared/fps_pkg.sv */
`default_nettype none

package fps_pkg;

  // Clock rate, used to turn times into cycle counts
  localparam int unsigned CLK_KHZ = 10000;

  // Times as specified, in their own units
  localparam int unsigned TRAN_TIME_MS = 3600;
  localparam int unsigned OVL_TIME_MS  = 100;
  localparam int unsigned OFF_TIME_MS  = 150;
  localparam int unsigned SS_TIME_MS   = 10;
  localparam int unsigned AREC_TIME_MS = 1000;
  localparam int unsigned LHI_TIME_US  = 50;
  localparam int unsigned LLO_TIME_US  = 350;
  localparam int unsigned SUP_TIME_US  = 10;

  // Least times round up to whole cycles
  function automatic int unsigned ms_cycles(input int unsigned ms);
    return ms * CLK_KHZ;
  endfunction

  function automatic int unsigned us_cycles(input int unsigned us);
    return (us * CLK_KHZ + 999) / 1000;
  endfunction

  localparam int unsigned LHI_CYCLES = us_cycles(LHI_TIME_US);
  localparam int unsigned LLO_CYCLES = us_cycles(LLO_TIME_US);
  localparam int unsigned SUP_CYCLES = us_cycles(SUP_TIME_US);

  // Winding-short consecutive cycle count
  localparam logic [2:0] WS_COUNT = 3'h4;

  // Timer slots
  localparam int T_TRAN = 0;
  localparam int T_OVL  = 1;
  localparam int T_OFF  = 2;
  localparam int T_LHI  = 3;
  localparam int T_LLO  = 4;
  localparam int T_UV   = 5;
  localparam int T_OV   = 6;
  localparam int T_SS   = 7;
  localparam int T_AREC = 8;
  localparam int T_NUM  = 9;

  typedef enum logic [2:0] {
    ST_WAIT_VCC,
    ST_SOFT,
    ST_RUN,
    ST_LATCHED,
    ST_AUTOREC,
    ST_BROWNOUT,
    ST_THERMAL,
    ST_OFF
  } fps_state_t;

  typedef struct packed {
    fps_state_t state;
    logic [2:0] ws_cnt;
    logic       ws_seen;
    logic       maxon_hold;
    logic       gate;
    logic       hv;
    logic       sup;
    logic       dbl;
    logic       lat;
    logic       arec;
  } fps_top_state_t;

endpackage

`default_nettype wire

/* File: shared/fps_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface fps_tmr_if;
  logic run;
  logic expired;
  modport ctl (output run, input expired);
  modport tmr (input run, output expired);
endinterface

`default_nettype wire

/* File: core/fps_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module fps_timer
  import fps_pkg::*;
#(
  parameter int unsigned LIMIT = 100
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Run and expiry
  fps_tmr_if.tmr   port
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        expired;
  } fps_tmr_state_t;

  fps_tmr_state_t s;
  fps_tmr_state_t next_s;

  // Counts while run is held, restarts from zero the moment it drops
  always_comb begin
    next_s = s;
    if (port.run) begin
      if (s.cnt < LIMIT) begin
        next_s.cnt = s.cnt + 32'h1;
      end
      next_s.expired = (s.cnt >= LIMIT - 1);
    end else begin
      next_s.cnt     = 32'h0;
      next_s.expired = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.expired = s.expired;

endmodule

`default_nettype wire

/* File: core/fps_top.sv */
// How it works
// R1: Transient comparator runs a 3.6 s timer; expiry enters protection, latched or autorecovery.
// R2: Overload timer also counts when transient delivery turns into current-limit overload.
// R3: Converter runs only inside the latch window; leaving it latches off.
// R4: Latch excursions shorter than 50 us high or 350 us low are ignored.
// R5: Latched state clears only on brown-out, thermal shutdown or supply fall to reset level.
// R6: Latch input ignored until turn-on; high latch then checked before switching starts.
// R7: Low latch condition is acted on only after soft-start completes.
// R8: Latch input source current is doubled during soft-start, normal afterwards.
// R9: Thermal shutdown stops gate at once, enters low-power off, keeps supply alive.
// R10: Thermal shutdown clearing re-enables a regular start-up with soft-start.
// R11: Thermal shutdown also disables the high-voltage start-up source.
// R12: Feedback below off level for 150 ms stops device and internal supply.
// R13: Winding-short trip on four consecutive switching cycles enters protection.
// R14: Overload timer clears when setpoint falls below current limit before expiry.
// R15: Pulse ended by maximum on-time also starts the overload timer.
// R16: Supply under or over voltage counts only after a 10 us filter; overvoltage then latches, undervoltage follows the option.
// R17: Brown-out stops switching; restart needs line start level and supply turn-on.
`timescale 1ns/1ps
`default_nettype none

module fps_top
  import fps_pkg::*;
#(
  parameter int unsigned TRAN_CYCLES = ms_cycles(TRAN_TIME_MS),
  parameter int unsigned OVL_CYCLES  = ms_cycles(OVL_TIME_MS),
  parameter int unsigned OFF_CYCLES  = ms_cycles(OFF_TIME_MS),
  parameter int unsigned SS_CYCLES   = ms_cycles(SS_TIME_MS),
  parameter int unsigned AREC_CYCLES = ms_cycles(AREC_TIME_MS)
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Option strap
  input  wire logic option_autorecovery,
  // Current sense comparators and cycle events
  input  wire logic cs_over_transient,
  input  wire logic cs_at_limit,
  input  wire logic max_on_end,
  input  wire logic cycle_end,
  input  wire logic winding_short_trip,
  // Latch input comparators
  input  wire logic latch_high,
  input  wire logic latch_low,
  // Supply, line and feedback comparators
  input  wire logic vcc_on,
  input  wire logic vcc_reset,
  input  wire logic vcc_uv,
  input  wire logic vcc_ov,
  input  wire logic line_brownout,
  input  wire logic line_start_ok,
  input  wire logic fb_below_off,
  input  wire logic fb_above_on,
  input  wire logic thermal_shutdown,
  // Controls to the power stage
  output logic      gate_drive_output,
  output logic      hv_source_enable,
  output logic      internal_supply_on,
  output logic      latch_input_softstart_current,
  output logic      protection_latched,
  output logic      autorecovery_wait
);

  fps_top_state_t s;
  fps_top_state_t next_s;
  fps_tmr_if      tmr [T_NUM] ();

  logic [T_NUM-1:0] exp_v;
  logic             active;
  logic             ws_now;
  logic             ws_fault;
  logic             hard_fault;
  logic             soft_fault;

  // Limits per slot, in slot order
  localparam int unsigned LIMS [T_NUM] = '{
    TRAN_CYCLES, OVL_CYCLES, OFF_CYCLES, LHI_CYCLES, LLO_CYCLES,
    SUP_CYCLES, SUP_CYCLES, SS_CYCLES, AREC_CYCLES
  };

  // One timer per slot: seven qualifying timers, plus soft-start and autorecovery
  for (genvar gi = 0; gi < T_NUM; gi++) begin : g_tmr
    fps_timer #(
      .LIMIT (LIMS[gi])
    ) u_tmr (
      .clock (clock),
      .rst   (rst),
      .port  (tmr[gi])
    );
    assign exp_v[gi] = tmr[gi].expired;
  end

  assign active = (s.state == ST_SOFT) || (s.state == ST_RUN);

  // Timer run terms; dropping run clears the timer
  assign tmr[T_TRAN].run = active && cs_over_transient; // R1
  assign tmr[T_OVL].run  = active && (cs_at_limit || s.maxon_hold || max_on_end); // R2 R14 R15
  assign tmr[T_OFF].run  = active && fb_below_off; // R12
  assign tmr[T_LHI].run  = active && latch_high; // R4
  assign tmr[T_LLO].run  = (s.state == ST_RUN) && latch_low; // R4 R7
  assign tmr[T_UV].run   = active && vcc_uv; // R16
  assign tmr[T_OV].run   = active && vcc_ov; // R16
  assign tmr[T_SS].run   = (s.state == ST_SOFT);
  assign tmr[T_AREC].run = (s.state == ST_AUTOREC);

  // A trip this cycle counts even if the cycle ends in the same clock
  assign ws_now   = s.ws_seen || winding_short_trip;
  assign ws_fault = active && cycle_end && ws_now && (s.ws_cnt == WS_COUNT - 3'h1); // R13

  // Latch-window, winding-short and overvoltage faults always latch
  assign hard_fault = ws_fault || (active && (exp_v[T_LHI] || exp_v[T_OV])) ||
                      ((s.state == ST_RUN) && exp_v[T_LLO]); // R3 R7 R16

  // Transient and overload timer faults and undervoltage follow the option
  assign soft_fault = active && (exp_v[T_TRAN] || exp_v[T_OVL] || exp_v[T_UV]); // R1 R16

  always_comb begin
    next_s = s;

    // Winding-short consecutive counter, kept per switching cycle
    if (cycle_end) begin
      next_s.ws_seen = 1'b0;
      if (ws_now && s.ws_cnt != WS_COUNT) begin
        next_s.ws_cnt = s.ws_cnt + 3'h1; // R13
      end else if (!ws_now) begin
        next_s.ws_cnt = 3'h0;
      end
    end else if (winding_short_trip) begin
      next_s.ws_seen = 1'b1;
    end

    // Max on-time end holds the overload timer until a normal cycle end
    if (max_on_end) begin
      next_s.maxon_hold = 1'b1; // R15
    end else if (cycle_end) begin
      next_s.maxon_hold = 1'b0;
    end

    case (s.state)
      ST_WAIT_VCC: begin
        // Latch comparators are not trusted before turn-on
        if (vcc_on && line_start_ok) begin
          if (latch_high) begin
            next_s.state = ST_LATCHED; // R6
          end else begin
            next_s.state = ST_SOFT; // R6
          end
        end
      end
      ST_SOFT, ST_RUN: begin
        if (hard_fault) begin
          next_s.state = ST_LATCHED; // R3
        end else if (soft_fault) begin
          next_s.state = option_autorecovery ? ST_AUTOREC : ST_LATCHED; // R1
        end else if (exp_v[T_OFF]) begin
          next_s.state = ST_OFF; // R12
        end else if (s.state == ST_SOFT && exp_v[T_SS]) begin
          next_s.state = ST_RUN; // R7
        end
      end
      ST_LATCHED: begin
        next_s.state = ST_LATCHED; // R5
      end
      ST_AUTOREC: begin
        if (exp_v[T_AREC]) begin
          next_s.state = ST_WAIT_VCC;
        end
      end
      ST_BROWNOUT: begin
        // Waiting state re-checks both line and supply
        if (!line_brownout && line_start_ok) begin
          next_s.state = ST_WAIT_VCC; // R17
        end
      end
      ST_THERMAL: begin
        if (!thermal_shutdown) begin
          next_s.state = ST_WAIT_VCC; // R10
        end
      end
      ST_OFF: begin
        if (line_start_ok && vcc_on && fb_above_on) begin
          next_s.state = ST_WAIT_VCC; // R12
        end
      end
      default: begin
        next_s.state = ST_WAIT_VCC;
      end
    endcase

    // Overrides: supply reset beats thermal, thermal beats brown-out
    if (vcc_reset) begin
      next_s.state = ST_WAIT_VCC; // R5
    end else if (thermal_shutdown) begin
      next_s.state = ST_THERMAL; // R9
    end else if (line_brownout) begin
      next_s.state = ST_BROWNOUT; // R5 R17
    end

    // Outputs decoded from the next state so they leave a flip-flop
    next_s.gate = (next_s.state == ST_SOFT) || (next_s.state == ST_RUN); // R3 R9
    next_s.hv   = (next_s.state != ST_THERMAL) && (next_s.state != ST_OFF); // R11
    next_s.sup  = (next_s.state != ST_OFF); // R9 R12
    next_s.dbl  = (next_s.state == ST_SOFT); // R8
    next_s.lat  = (next_s.state == ST_LATCHED);
    next_s.arec = (next_s.state == ST_AUTOREC);
    if (!next_s.gate) begin
      next_s.ws_cnt     = 3'h0;
      next_s.ws_seen    = 1'b0;
      next_s.maxon_hold = 1'b0;
    end
  end

  // Reset leaves every output off except the supplies
  always_ff @(posedge clock) begin
    if (rst) begin
      s      <= '0;
      s.hv   <= 1'b1;
      s.sup  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign gate_drive_output             = s.gate;
  assign hv_source_enable              = s.hv;
  assign internal_supply_on            = s.sup;
  assign latch_input_softstart_current = s.dbl;
  assign protection_latched            = s.lat;
  assign autorecovery_wait             = s.arec;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence therm_hit;
    thermal_shutdown && !vcc_reset;
  endsequence

  sequence stopped_dead;
    !gate_drive_output && !hv_source_enable && internal_supply_on;
  endsequence

  sequence no_override;
    !vcc_reset && !thermal_shutdown && !line_brownout;
  endsequence

  therm_stop_a: assert property (therm_hit |=> stopped_dead) // R9 R11
    else $error("thermal shutdown did not stop driver and source");

  // Release goes back through the supply wait, so the next run starts in soft-start
  therm_restart_a: assert property ( // R10
    (s.state == ST_THERMAL) ##0 no_override
    |=> (s.state == ST_WAIT_VCC) && !gate_drive_output ##1 (s.state != ST_RUN))
    else $error("thermal release skipped regular start-up");

  latch_hold_a: assert property (
    (s.state == ST_LATCHED) ##0 no_override |=> protection_latched && !gate_drive_output) // R5
    else $error("latched state released without reset or brown-out");

  high_start_a: assert property (
    (s.state == ST_WAIT_VCC) && vcc_on && line_start_ok && latch_high ##0 no_override
    |=> protection_latched) // R6
    else $error("switching began with high latch present");

  ss_double_a: assert property (
    latch_input_softstart_current == (gate_drive_output && s.state == ST_SOFT)) // R8
    else $error("softstart current mismatch");

  low_blank_a: assert property ($rose(exp_v[T_LLO]) |-> $past(latch_low, 8)
    && $past(s.state == ST_RUN, 8)) // R4 R7
    else $error("low latch qualified too early");

  high_blank_a: assert property ($rose(exp_v[T_LHI]) |-> $past(latch_high, 8)) // R4
    else $error("high latch qualified too early");

  sup_filter_a: assert property ($rose(exp_v[T_UV]) |-> $past(vcc_uv, 8) && $past(vcc_uv, 4)) // R16
    else $error("undervoltage qualified without persistence");

  ovl_clear_a: assert property (!tmr[T_OVL].run |=> !exp_v[T_OVL] [*2]) // R14
    else $error("overload timer not cleared");

  ws_four_a: assert property (ws_fault ##0 no_override |=> protection_latched) // R13
    else $error("winding short did not latch");

  off_supply_a: assert property (
    active && exp_v[T_OFF] && !hard_fault && !soft_fault ##0 no_override
    |=> !internal_supply_on && !gate_drive_output) // R12
    else $error("off mode kept internal supply on");

  brown_a: assert property (line_brownout && !vcc_reset && !thermal_shutdown
    |=> !gate_drive_output ##1 !gate_drive_output) // R17
    else $error("brown-out did not stop switching");

endmodule

`default_nettype wire

/* File: tb/fps_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fps_stage_model (
  // Clock and driver state
  input  wire logic clock,
  input  wire logic gate_drive_output,
  // Fault commands from the bench
  input  wire logic cmd_short,
  input  wire logic cmd_maxon,
  // Cycle events back to the controller
  output logic      cycle_end,
  output logic      winding_short_trip,
  output logic      max_on_end
);
  logic [2:0] phase;

  // Quiet lines from time zero
  initial begin
    phase = 3'h0;
    {cycle_end, winding_short_trip, max_on_end} = 3'h0;
  end

  // Eight-clock switching cycle; no cycles at all while the driver is off
  always @(negedge clock) begin
    phase <= gate_drive_output ? phase + 3'h1 : 3'h0;
    cycle_end <= gate_drive_output && phase == 3'h7;
    winding_short_trip <= gate_drive_output && cmd_short && phase == 3'h7;
    max_on_end <= gate_drive_output && cmd_maxon && phase == 3'h7;
  end
endmodule

`default_nettype wire

/* File: tb/fps_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module fps_top_tb;
  import fps_pkg::*;
  // Short timers; transient kept long so overload wins the race
  localparam int SS = 40, TRAN = 400, OVL = 40, OFF = 40, AREC = 40;
  // Output vectors {gate, hv, supply, softstart, latched, autorec}
  localparam logic [5:0] RUN = 6'h38, SOFT = 6'h3c, LAT = 6'h1a;
  localparam logic [5:0] WAIT = 6'h18, ARW = 6'h19, THERM = 6'h08, OFFM = 6'h00;

  logic       clock, rst, option_autorecovery, cs_over_transient, cs_at_limit;
  logic       latch_high, latch_low, vcc_on, vcc_reset, vcc_uv, vcc_ov;
  logic       line_brownout, line_start_ok, fb_below_off, fb_above_on;
  logic       thermal_shutdown, cmd_short, cmd_maxon;
  wire logic  max_on_end, cycle_end, winding_short_trip;
  wire logic  [5:0] outs;
  logic [5:0] exp_q[$];
  logic [5:0] e;
  int         errors, total_checks, seed, d, i;

  fps_top #(.TRAN_CYCLES(TRAN), .OVL_CYCLES(OVL), .OFF_CYCLES(OFF), .SS_CYCLES(SS),
    .AREC_CYCLES(AREC)) fps_top_inst (.clock(clock), .rst(rst),
    .option_autorecovery(option_autorecovery), .cs_over_transient(cs_over_transient),
    .cs_at_limit(cs_at_limit), .max_on_end(max_on_end), .cycle_end(cycle_end),
    .winding_short_trip(winding_short_trip), .latch_high(latch_high),
    .latch_low(latch_low), .vcc_on(vcc_on), .vcc_reset(vcc_reset), .vcc_uv(vcc_uv),
    .vcc_ov(vcc_ov), .line_brownout(line_brownout), .line_start_ok(line_start_ok),
    .fb_below_off(fb_below_off), .fb_above_on(fb_above_on),
    .thermal_shutdown(thermal_shutdown), .gate_drive_output(outs[5]),
    .hv_source_enable(outs[4]), .internal_supply_on(outs[3]),
    .latch_input_softstart_current(outs[2]), .protection_latched(outs[1]),
    .autorecovery_wait(outs[0]));

  fps_stage_model fps_stage_model_inst (.clock(clock), .gate_drive_output(outs[5]),
    .cmd_short(cmd_short), .cmd_maxon(cmd_maxon), .cycle_end(cycle_end),
    .winding_short_trip(winding_short_trip), .max_on_end(max_on_end));

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Bounded wait for a whole output vector; a miss ends the run
  task automatic wait_for(input logic [5:0] v, input int bound);
    for (i = 0; i < bound && outs !== v; i++) @(negedge clock);
    if (outs !== v) begin
      errors++;
      $display("ERROR outputs expected %h seen %h", v, outs);
      test_done();
    end else begin
      exp_q.push_back(v);
    end
  endtask

  task automatic start(input int b);
    vcc_on = 1'b1;
    line_start_ok = 1'b1;
    wait_for(SOFT, b);
    wait_for(RUN, SS + 10);
  endtask

  task automatic reboot();
    vcc_reset = 1'b1;
    vcc_on = 1'b0;
    tick(2);
    exp_q.push_back(WAIT);
    vcc_reset = 1'b0;
    start(4);
  endtask

  // Noted vectors are compared before the edge's own updates land
  always @(posedge clock) begin
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("gate", outs[5], e[5]);
      check("hv_source", outs[4], e[4]);
      check("supply", outs[3], e[3]);
      check("softstart_current", outs[2], e[2]);
      check("latched", outs[1], e[1]);
      check("autorec", outs[0], e[0]);
    end
  end

  initial begin
    {rst, option_autorecovery, cs_over_transient, cs_at_limit, latch_high, latch_low,
      vcc_on, vcc_reset, vcc_uv, vcc_ov, line_brownout, line_start_ok, fb_below_off,
      thermal_shutdown, cmd_short, cmd_maxon} = '0;
    fb_above_on = 1'b1;
    seed = 11400;
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    exp_q.push_back(WAIT);
    // High latch present at turn-on keeps the driver off
    latch_high = 1'b1;
    vcc_on = 1'b1;
    line_start_ok = 1'b1;
    wait_for(LAT, 4);
    latch_high = 1'b0;
    tick(50);
    exp_q.push_back(LAT);
    reboot();
    // Short high excursion blanked, long one latches
    d = 100 + {$random(seed)} % 300;
    latch_high = 1'b1;
    tick(d);
    latch_high = 1'b0;
    tick(5);
    exp_q.push_back(RUN);
    latch_high = 1'b1;
    wait_for(LAT, 510);
    latch_high = 1'b0;
    // Brown-out releases the latch; restart needs line start level
    line_brownout = 1'b1;
    line_start_ok = 1'b0;
    wait_for(WAIT, 3);
    line_brownout = 1'b0;
    tick(20);
    exp_q.push_back(WAIT);
    start(4);
    // Low latch: 3000 cycles blanked, longer latches
    latch_low = 1'b1;
    tick(3000);
    exp_q.push_back(RUN);
    wait_for(LAT, 600);
    latch_low = 1'b0;
    reboot();
    // Thermal shutdown and regular restart
    thermal_shutdown = 1'b1;
    tick(1);
    exp_q.push_back(THERM);
    tick(20);
    exp_q.push_back(THERM);
    thermal_shutdown = 1'b0;
    start(4);
    // Off mode after the feedback timer
    fb_below_off = 1'b1;
    fb_above_on = 1'b0;
    tick(OFF - 5);
    exp_q.push_back(RUN);
    wait_for(OFFM, 20);
    fb_below_off = 1'b0;
    tick(10);
    exp_q.push_back(OFFM);
    fb_above_on = 1'b1;
    start(4);
    // Transient timer, latched then autorecovery option
    cs_over_transient = 1'b1;
    tick(TRAN - 10);
    exp_q.push_back(RUN);
    wait_for(LAT, 20);
    cs_over_transient = 1'b0;
    reboot();
    option_autorecovery = 1'b1;
    cs_over_transient = 1'b1;
    wait_for(ARW, TRAN + 10);
    cs_over_transient = 1'b0;
    start(AREC + 10);
    // Supply undervoltage autorecovers under the option
    vcc_uv = 1'b1;
    wait_for(ARW, 110);
    vcc_uv = 1'b0;
    start(AREC + 10);
    option_autorecovery = 1'b0;
    // Transient turning into overload trips on the overload timer
    cs_over_transient = 1'b1;
    tick(10);
    cs_at_limit = 1'b1;
    wait_for(LAT, OVL + 10);
    {cs_over_transient, cs_at_limit} = 2'h0;
    reboot();
    // Setpoint dropping back clears the overload timer
    repeat (3) begin
      cs_at_limit = 1'b1;
      tick(OVL - 10);
      cs_at_limit = 1'b0;
      tick(3);
    end
    exp_q.push_back(RUN);
    cmd_maxon = 1'b1;
    wait_for(LAT, OVL + 20);
    cmd_maxon = 1'b0;
    reboot();
    // Three trips then a clean cycle, then four in a row
    for (i = 0; i < 20 && cycle_end !== 1'b1; i++) @(negedge clock);
    check("cycle_align", cycle_end, 1'b1);
    // Without a cycle to align to the trip count below means nothing
    if (cycle_end !== 1'b1) test_done();
    cmd_short = 1'b1;
    tick(27);
    cmd_short = 1'b0;
    tick(8);
    exp_q.push_back(RUN);
    cmd_short = 1'b1;
    wait_for(LAT, 45);
    cmd_short = 1'b0;
    reboot();
    // Supply filter: short undervoltage ignored, long overvoltage latches
    vcc_uv = 1'b1;
    tick(50);
    vcc_uv = 1'b0;
    tick(3);
    exp_q.push_back(RUN);
    vcc_ov = 1'b1;
    wait_for(LAT, 110);
    vcc_ov = 1'b0;
    tick(2);
    test_done();
  end
endmodule

`default_nettype wire
